// ==== verilog/gear_path_pkg.sv ====
package gear_path_pkg;

    // clock and time base
    localparam int CLK_PERIOD_NS      = 8;
    localparam int MS_TIME_NS         = 1_000_000;
    localparam int CYCLES_PER_MS      = (MS_TIME_NS + CLK_PERIOD_NS - 1)
                                        / CLK_PERIOD_NS;

    // setting defaults and limits
    localparam logic [15:0] GEAR_A_NUM_RST = 16'h0000;
    localparam logic [15:0] GEAR_A_DEN_RST = 16'h2710;
    localparam logic [31:0] GEAR_B_NUM_RST = 32'h0000_0000;
    localparam logic [31:0] GEAR_B_DEN_RST = 32'h0000_2710;
    localparam logic [31:0] GEAR_B_MAX     = 32'h7FFF_FFFF;
    localparam logic [1:0]  GEAR_SEL_RST   = 2'h0;
    localparam logic [1:0]  GEAR_SEL_A     = 2'h0;
    localparam logic [1:0]  GEAR_SEL_B     = 2'h1;
    localparam logic [1:0]  GEAR_SEL_PIN   = 2'h2;
    localparam logic [13:0] SMOOTH_MIN_MS  = 14'h0001;
    localparam logic [13:0] SMOOTH_MAX_MS  = 14'h2710;
    localparam logic [13:0] SMOOTH_RST_MS  = 14'h0001;
    localparam logic [13:0] RAMP_MAX_MS    = 14'h2710;
    localparam logic [13:0] RAMP_RST_MS    = 14'h0000;

    // command_input_options digit bits
    localparam int OPT_INHIBIT_BIT = 0;
    localparam int OPT_CLEAR_BIT   = 1;
    localparam logic [3:0] OPT_RST = 4'h0;

    // encoder counts per motor revolution used when a numerator is zero
    localparam logic [31:0] COUNTS_PER_REV_DEF = 32'h0002_0000;

    // datapath widths
    localparam int RATE_W  = 17;
    localparam int SCALE_W = 33;

    typedef struct packed {
        logic [31:0] num;
        logic [31:0] den;
    } gear_cfg_s;

    typedef enum logic [1:0] {
        SCALE_IDLE,
        SCALE_DIV
    } scale_state_e;

endpackage

// ==== verilog/seq_divider.sv ====
`timescale 1ns/10ps
// restoring divider, one quotient bit per clock; start restarts it
module seq_divider #(
    parameter int W = 33
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // request
    input  wire logic         start,
    input  wire logic [W-1:0] dividend,
    input  wire logic [W-1:0] divisor,
    // answer
    output logic              busy,
    output logic              done,
    output logic [W-1:0]      quotient,
    output logic [W-1:0]      remainder
);
    logic [W:0]         rs;
    logic [W-1:0]       d_reg;
    logic [$clog2(W+1)-1:0] cnt_reg;

    generate
        if (W < 2) begin : g_bad_w
            $error("seq_divider width too small");
        end
    endgenerate

    assign rs = {remainder, quotient[W-1]};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy      <= 1'b0;
            done      <= 1'b0;
            quotient  <= '0;
            remainder <= '0;
            d_reg     <= '0;
            cnt_reg   <= '0;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy      <= 1'b1;
                quotient  <= dividend;
                remainder <= '0;
                d_reg     <= divisor;
                cnt_reg   <= ($clog2(W+1))'(W);
            end else if (busy) begin
                if (rs >= {1'b0, d_reg}) begin
                    remainder <= W'(rs - {1'b0, d_reg});
                    quotient  <= {quotient[W-2:0], 1'b1};
                end else begin
                    remainder <= rs[W-1:0];
                    quotient  <= {quotient[W-2:0], 1'b0};
                end
                cnt_reg <= cnt_reg - 1'b1;
                if (cnt_reg == 1) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule // seq_divider

// ==== verilog/rate_ramp.sv ====
`timescale 1ns/10ps
// moves the output rate toward the target at rated_rate per ramp time
module rate_ramp #(
    parameter int RW  = 17,
    parameter int CYC = 125000
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          clear,
    // setting
    input  wire logic [RW-1:0] target,
    input  wire logic [13:0]   accel_ms,
    input  wire logic [13:0]   decel_ms,
    input  wire logic [RW-1:0] rated_rate,
    // shaped rate, pulses per ms
    output logic [RW-1:0]      rate
);
    logic [13:0] time_ms;
    logic [31:0] thr;
    logic [32:0] acc_reg;
    logic [32:0] acc_sum;

    // slope is rated/ramp, so reaching a target takes ramp*target/rated
    always_comb begin
        time_ms = (rate < target) ? accel_ms : decel_ms;
        thr     = 32'(time_ms * 32'(CYC));
        acc_sum = acc_reg + 33'(rated_rate);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rate    <= '0;
            acc_reg <= '0;
        end else if (clear) begin
            rate    <= '0;
            acc_reg <= '0;
        end else if (rate == target) begin
            acc_reg <= '0;
        end else if (time_ms == 0 || rated_rate == 0) begin
            rate    <= target;
            acc_reg <= '0;
        end else if (acc_sum >= {1'b0, thr}) begin
            acc_reg <= acc_sum - {1'b0, thr};
            rate    <= (rate < target) ? rate + 1'b1 : rate - 1'b1;
        end else begin
            acc_reg <= acc_sum;
        end
    end
endmodule // rate_ramp

// ==== verilog/position_command_gear_path.sv ====
`timescale 1ns/10ps
// Summary of operation
// - gear A numerator 0..65535, applied immediately
// - gear A denominator 1..65535, zero never used
// - gear B pair stored as 31-bit positive
// - selector picks A, B, or pin switchover
// - command equals pulses times numerator over denominator
// - zero numerator: denominator is pulses per rev
// - smoothing 1..10000 ms, pulse total preserved
// - ramp 0..10000 ms, zero means none
// - ramp time scales with target over rated
// - inhibit input stops pulse counting
// - option bit 0 enables inhibit input
// - clear input zeroes the deviation register
// - option bit 1 enables clear function
// - clear stops motor, discards remaining pulses
module position_command_gear_path #(
    parameter int          MS_CYCLES      = gear_path_pkg::CYCLES_PER_MS,
    parameter logic [31:0] COUNTS_PER_REV = gear_path_pkg::COUNTS_PER_REV_DEF,
    parameter int          DEV_W          = 40,
    parameter int          IN_W           = 16
) (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           rst,
    // command pins from the host
    input  wire logic                           cmd_pulse_in,
    input  wire logic                           cmd_dir_in,
    input  wire logic                           pulse_count_block_in,
    input  wire logic                           deviation_zero_in,
    input  wire logic                           gear_switch_in,
    // settings
    input  wire logic [15:0]                    gear_a_numerator,
    input  wire logic [15:0]                    gear_a_denominator,
    input  wire logic [31:0]                    gear_b_numerator,
    input  wire logic [31:0]                    gear_b_denominator,
    input  wire logic [1:0]                     gear_set_select,
    input  wire logic [13:0]                    command_smoothing_time,
    input  wire logic [13:0]                    ramp_accel_time,
    input  wire logic [13:0]                    ramp_decel_time,
    input  wire logic [3:0]                     command_input_options,
    input  wire logic [gear_path_pkg::RATE_W-1:0] rated_rate,
    // motor command out
    output logic                                motor_step_out,
    output logic                                motor_dir_out,
    // status
    output logic signed [DEV_W-1:0]             position_deviation,
    output logic                                active_gear_b,
    output logic                                scaler_busy
);
    localparam int RW = gear_path_pkg::RATE_W;
    localparam int SW = gear_path_pkg::SCALE_W;
    localparam logic [RW:0] MS_CYC = (RW+1)'(MS_CYCLES);

    generate
        if (MS_CYCLES <= DEV_W || MS_CYCLES >= (1 << RW)) begin : g_bad_ms
            $error("MS_CYCLES does not fit the rate width");
        end
        if (DEV_W < SW + 2 || IN_W < 2) begin : g_bad_w
            $error("deviation or input counter too narrow");
        end
    endgenerate

    // pin synchronisers, stage one is read only by stage two
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic       pulse_prev_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_reg      <= '0;
            sync2_reg      <= '0;
            pulse_prev_reg <= 1'b0;
        end else begin
            sync1_reg      <= {gear_switch_in, deviation_zero_in,
                               pulse_count_block_in, cmd_dir_in,
                               cmd_pulse_in};
            sync2_reg      <= sync1_reg;
            pulse_prev_reg <= sync2_reg[0];
        end
    end

    logic pulse_edge;
    logic inhibit;
    logic clear;
    assign pulse_edge = sync2_reg[0] & ~pulse_prev_reg;
    assign inhibit = sync2_reg[2]
                   & command_input_options[gear_path_pkg::OPT_INHIBIT_BIT];
    assign clear = sync2_reg[3]
                 & command_input_options[gear_path_pkg::OPT_CLEAR_BIT];

    // gear pair in use, zero denominators forced to one
    gear_path_pkg::gear_cfg_s cfg_a;
    gear_path_pkg::gear_cfg_s cfg_b;
    gear_path_pkg::gear_cfg_s cfg_sel;
    logic                     want_b;
    logic [31:0]              num_eff;

    always_comb begin
        cfg_a.num = {16'h0000, gear_a_numerator};
        cfg_a.den = (gear_a_denominator == 0) ? 32'h0000_0001
                  : {16'h0000, gear_a_denominator};
        cfg_b.num = gear_b_numerator & gear_path_pkg::GEAR_B_MAX;
        cfg_b.den = ((gear_b_denominator & gear_path_pkg::GEAR_B_MAX) == 0)
                  ? 32'h0000_0001
                  : (gear_b_denominator & gear_path_pkg::GEAR_B_MAX);
        unique case (gear_set_select)
            gear_path_pkg::GEAR_SEL_B:   want_b = 1'b1;
            gear_path_pkg::GEAR_SEL_PIN: want_b = sync2_reg[4];
            default:                     want_b = 1'b0;
        endcase
        cfg_sel = want_b ? cfg_b : cfg_a;
        num_eff = (cfg_sel.num == 0) ? COUNTS_PER_REV : cfg_sel.num;
    end

    // incoming pulses wait here while the scaler is busy
    logic signed [IN_W-1:0] in_count_reg;
    logic                   take;
    logic                   take_dir;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_count_reg <= '0;
        end else if (clear) begin
            in_count_reg <= '0;
        end else begin
            in_count_reg <= in_count_reg
                + ((pulse_edge && !inhibit)
                   ? (sync2_reg[1] ? IN_W'(-1) : IN_W'(1)) : IN_W'(0))
                - (take ? (take_dir ? IN_W'(-1) : IN_W'(1)) : IN_W'(0));
        end
    end

    // scaler: one command pulse per division, remainder kept
    gear_path_pkg::scale_state_e scale_state_reg;
    logic [31:0]                 rem_reg;
    logic [31:0]                 den_reg;
    logic                        rev_reg;
    logic                        div_start;
    logic [SW-1:0]               div_dividend;
    logic                        div_done;
    logic [SW-1:0]               div_q;
    logic [SW-1:0]               div_r;
    logic                        short_rev;

    assign take_dir  = in_count_reg < 0;
    assign take      = (scale_state_reg == gear_path_pkg::SCALE_IDLE)
                     && (in_count_reg != 0) && !clear;
    assign short_rev = take_dir && (num_eff <= rem_reg);
    assign div_start = take && !short_rev;

    // reverse uses ceiling so position stays floor(X*num/den)
    always_comb begin
        if (take_dir) begin
            div_dividend = SW'(num_eff) - SW'(rem_reg) + SW'(cfg_sel.den)
                         - SW'(1);
        end else begin
            div_dividend = SW'(rem_reg) + SW'(num_eff);
        end
    end

    seq_divider #(
        .W(SW)
    ) u_gear_div (
        .clk      (clk),
        .rst      (rst),
        .start    (div_start),
        .dividend (div_dividend),
        .divisor  (SW'(cfg_sel.den)),
        .busy     (),
        .done     (div_done),
        .quotient (div_q),
        .remainder(div_r)
    );

    logic gear_apply;
    assign gear_apply = (scale_state_reg == gear_path_pkg::SCALE_DIV)
                      && div_done && !clear;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scale_state_reg <= gear_path_pkg::SCALE_IDLE;
            rem_reg         <= '0;
            den_reg         <= 32'h0000_0001;
            rev_reg         <= 1'b0;
            active_gear_b   <= 1'b0;
        end else if (clear) begin
            scale_state_reg <= gear_path_pkg::SCALE_IDLE;
            rem_reg         <= '0;
        end else begin
            unique case (scale_state_reg)
                gear_path_pkg::SCALE_IDLE: begin
                    if (take) begin
                        active_gear_b <= want_b;
                        den_reg       <= cfg_sel.den;
                        rev_reg       <= take_dir;
                        if (short_rev) begin
                            rem_reg <= rem_reg - num_eff;
                        end else begin
                            scale_state_reg <= gear_path_pkg::SCALE_DIV;
                        end
                    end
                end
                gear_path_pkg::SCALE_DIV: begin
                    if (div_done) begin
                        scale_state_reg <= gear_path_pkg::SCALE_IDLE;
                        rem_reg <= rev_reg
                            ? den_reg - 32'h0000_0001 - div_r[31:0]
                            : div_r[31:0];
                    end
                end
            endcase
        end
    end

    // deviation: scaled counts not yet sent to the motor
    logic signed [DEV_W-1:0] pend_reg;
    logic signed [DEV_W-1:0] pend_next;
    logic                    emit;
    logic [RW:0]             ph_reg;
    logic [RW:0]             ph_sum;
    logic [RW-1:0]           rate;

    assign ph_sum = ph_reg + (RW+1)'(rate);
    assign emit   = (ph_sum >= MS_CYC) && (pend_reg != 0);

    always_comb begin
        pend_next = pend_reg;
        if (gear_apply) begin
            if (rev_reg) begin
                pend_next = pend_next - DEV_W'(div_q);
            end else begin
                pend_next = pend_next + DEV_W'(div_q);
            end
        end
        if (emit) begin
            // only moves counts out, so the total is never altered
            pend_next = (pend_reg < 0) ? pend_next + DEV_W'(1)
                      : pend_next - DEV_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_reg <= '0;
        end else if (clear) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= pend_next;
        end
    end

    // millisecond tick and smoothing target, ceil(|dev| / T) per ms
    logic [31:0]      ms_cnt_reg;
    logic             ms_tick;
    logic [13:0]      smooth_ms;
    logic [13:0]      accel_ms;
    logic [13:0]      decel_ms;
    logic [DEV_W-1:0] pend_abs;
    logic             sm_done;
    logic [DEV_W-1:0] sm_q;
    logic [RW-1:0]    target_reg;

    assign ms_tick  = ms_cnt_reg == 32'(MS_CYCLES - 1);
    assign pend_abs = (pend_reg < 0) ? DEV_W'(-pend_reg) : DEV_W'(pend_reg);

    always_comb begin
        smooth_ms = command_smoothing_time;
        if (smooth_ms < gear_path_pkg::SMOOTH_MIN_MS) begin
            smooth_ms = gear_path_pkg::SMOOTH_MIN_MS;
        end else if (smooth_ms > gear_path_pkg::SMOOTH_MAX_MS) begin
            smooth_ms = gear_path_pkg::SMOOTH_MAX_MS;
        end
        accel_ms = (ramp_accel_time > gear_path_pkg::RAMP_MAX_MS)
                 ? gear_path_pkg::RAMP_MAX_MS : ramp_accel_time;
        decel_ms = (ramp_decel_time > gear_path_pkg::RAMP_MAX_MS)
                 ? gear_path_pkg::RAMP_MAX_MS : ramp_decel_time;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ms_cnt_reg <= '0;
        end else if (ms_tick) begin
            ms_cnt_reg <= '0;
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 32'h0000_0001;
        end
    end

    seq_divider #(
        .W(DEV_W)
    ) u_smooth_div (
        .clk      (clk),
        .rst      (rst),
        .start    (ms_tick),
        .dividend (pend_abs + DEV_W'(smooth_ms) - DEV_W'(1)),
        .divisor  (DEV_W'(smooth_ms)),
        .busy     (),
        .done     (sm_done),
        .quotient (sm_q),
        .remainder()
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            target_reg <= '0;
        end else if (clear) begin
            target_reg <= '0;
        end else if (sm_done) begin
            target_reg <= (sm_q > DEV_W'(MS_CYCLES)) ? RW'(MS_CYCLES)
                        : sm_q[RW-1:0];
        end
    end

    rate_ramp #(
        .RW (RW),
        .CYC(MS_CYCLES)
    ) u_ramp (
        .clk       (clk),
        .rst       (rst),
        .clear     (clear),
        .target    (target_reg),
        .accel_ms  (accel_ms),
        .decel_ms  (decel_ms),
        .rated_rate(rated_rate),
        .rate      (rate)
    );

    // spread rate pulses evenly over each millisecond
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph_reg             <= '0;
            motor_step_out     <= 1'b0;
            motor_dir_out      <= 1'b0;
            position_deviation <= '0;
            scaler_busy        <= 1'b0;
        end else begin
            ph_reg             <= (ph_sum >= MS_CYC) ? ph_sum - MS_CYC
                                : ph_sum;
            motor_step_out     <= emit && !clear;
            if (emit) begin
                motor_dir_out <= pend_reg < 0;
            end
            position_deviation <= clear ? '0 : pend_next;
            scaler_busy        <= (scale_state_reg != gear_path_pkg::SCALE_IDLE)
                                || (in_count_reg != 0);
        end
    end
endmodule // position_command_gear_path

// ==== verification/gear_path_props.sv ====
`timescale 1ns/10ps
module gear_path_props #(
    parameter int DEV_W = 40
) (
    // clock and reset
    input wire logic                    clk,
    input wire logic                    rst,
    // pins and settings
    input wire logic                    pulse_count_block_in,
    input wire logic                    deviation_zero_in,
    input wire logic [1:0]              gear_set_select,
    input wire logic [3:0]              command_input_options,
    // outputs
    input wire logic                    motor_step_out,
    input wire logic                    motor_dir_out,
    input wire logic signed [DEV_W-1:0] position_deviation,
    input wire logic                    active_gear_b,
    input wire logic                    scaler_busy
);
    logic [DEV_W-1:0] mag;
    logic [3:0]       inh_cnt;
    logic             clr_on;
    logic             inh_on;

    assign clr_on = deviation_zero_in && command_input_options[1];
    assign inh_on = pulse_count_block_in && command_input_options[0];
    assign mag = position_deviation[DEV_W-1] ? -position_deviation
                                              : position_deviation;

    // pulses still in the sync stages may land, so wait before judging
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inh_cnt <= 4'h0;
        end else if (!inh_on) begin
            inh_cnt <= 4'h0;
        end else if (inh_cnt != 4'hF) begin
            inh_cnt <= inh_cnt + 4'h1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    reset_quiet_a: assert property (
        $fell(rst) |-> !motor_step_out && !active_gear_b && !scaler_busy)
        else $error("outputs not idle after reset");
    clear_zero_a: assert property (
        clr_on [*5] |-> position_deviation == '0)
        else $error("deviation not cleared");
    clear_stop_a: assert property (
        clr_on [*5] |-> !motor_step_out && !scaler_busy)
        else $error("motion continues under clear");
    inhibit_hold_a: assert property (
        inh_cnt == 4'hF && !scaler_busy |=> !scaler_busy && mag <= $past(mag))
        else $error("pending grew while inhibited");
    step_pending_a: assert property (
        motor_step_out |-> $past(position_deviation) != '0)
        else $error("step with nothing pending");
    step_dir_a: assert property (
        motor_step_out |-> motor_dir_out == $past(position_deviation[DEV_W-1]))
        else $error("step direction wrong");
    gear_latch_a: assert property (
        $changed(active_gear_b) |-> scaler_busy)
        else $error("gear changed outside a pulse");
    gear_fixed_a: assert property (
        $changed(active_gear_b) && gear_set_select != gear_path_pkg::GEAR_SEL_PIN
        |-> active_gear_b == (gear_set_select == gear_path_pkg::GEAR_SEL_B))
        else $error("wrong gear set latched");
endmodule // gear_path_props

bind position_command_gear_path gear_path_props #(.DEV_W(DEV_W))
    i_gear_path_props (.clk, .rst, .pulse_count_block_in,
    .deviation_zero_in, .gear_set_select, .command_input_options,
    .motor_step_out, .motor_dir_out, .position_deviation, .active_gear_b,
    .scaler_busy);

// ==== verification/host_pulse_source.sv ====
`timescale 1ns/10ps
module host_pulse_source (
    // clock
    input  wire logic clk,
    // command pins
    output logic      pulse_out,
    output logic      dir_out
);
    initial begin
        pulse_out = 1'b0;
        dir_out   = 1'b0;
    end
    // 3 high, 38 low: clears the pin filter and stays under the scaler rate
    task automatic send(input int n, input logic rev);
        repeat (n) begin
            @(posedge clk);
            dir_out   <= rev;
            pulse_out <= 1'b1;
            repeat (3) @(posedge clk);
            pulse_out <= 1'b0;
            repeat (37) @(posedge clk);
        end
    endtask
endmodule // host_pulse_source

// ==== verification/test_position_command_gear_path.sv ====
`timescale 1ns/10ps
module test_position_command_gear_path;
    typedef struct {
        int sel, pin, num, den, n, rev, smooth, ramp, inh, blk, exp;
    } row_s;
    // sel pin num den pulses rev smooth ramp inh blk steps
    // ratios kept in 0.01..100 and reduced except 65535/65535, smoothing on at x100
    row_s rows [10] = '{
        '{2'h0,1'h0,2'h3,2'h2,3'h5,1'h0,1'h1,1'h0,1'h0,1'h0,3'h7},
        '{2'h1,1'h0,2'h3,1'h1,2'h2,1'h1,1'h1,1'h0,1'h0,1'h0,-3'h6},
        '{2'h0,1'h0,1'h0,16'h4000,2'h3,1'h0,1'h1,1'h0,1'h0,1'h0,5'h18},
        '{2'h2,1'h1,3'h5,1'h1,3'h4,1'h0,1'h1,1'h1,1'h0,1'h0,5'h14},
        '{2'h2,1'h0,2'h2,1'h1,3'h4,1'h0,1'h1,1'h0,1'h0,1'h0,4'h8},
        '{2'h3,1'h0,2'h2,1'h1,2'h3,1'h0,1'h1,1'h0,1'h0,1'h0,3'h6},
        '{2'h1,1'h0,8'h64,1'h1,2'h2,1'h0,2'h3,1'h0,1'h0,1'h0,8'hC8},
        '{2'h0,1'h0,16'hFFFF,16'hFFFF,2'h3,1'h0,1'h1,1'h0,1'h0,1'h0,2'h3},
        '{2'h0,1'h0,1'h1,1'h1,2'h3,1'h0,1'h1,1'h0,1'h1,1'h1,1'h0},
        '{2'h0,1'h0,1'h1,1'h1,2'h3,1'h0,1'h1,1'h0,1'h0,1'h1,2'h3}
    };
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cmd_pulse_in;
    logic        cmd_dir_in;
    logic        pulse_count_block_in = 1'b0;
    logic        deviation_zero_in = 1'b0;
    logic        gear_switch_in = 1'b0;
    logic [15:0] gear_a_numerator = gear_path_pkg::GEAR_A_NUM_RST;
    logic [15:0] gear_a_denominator = gear_path_pkg::GEAR_A_DEN_RST;
    logic [31:0] gear_b_numerator = gear_path_pkg::GEAR_B_NUM_RST;
    logic [31:0] gear_b_denominator = gear_path_pkg::GEAR_B_DEN_RST;
    logic [1:0]  gear_set_select = gear_path_pkg::GEAR_SEL_RST;
    logic [13:0] command_smoothing_time = gear_path_pkg::SMOOTH_RST_MS;
    logic [13:0] ramp_accel_time = gear_path_pkg::RAMP_RST_MS;
    logic [13:0] ramp_decel_time = gear_path_pkg::RAMP_RST_MS;
    logic [3:0]  command_input_options = gear_path_pkg::OPT_RST;
    logic [16:0] rated_rate = 17'h0_0000;
    logic        motor_step_out;
    logic        motor_dir_out;
    logic signed [39:0] position_deviation;
    logic        active_gear_b;
    logic        scaler_busy;
    int          step_sum = 0;
    int          base;
    int          err_total = 0;
    int          tests_run = 0;

    always #4 clk = ~clk;

    host_pulse_source i_host_pulse_source (.clk, .pulse_out(cmd_pulse_in),
        .dir_out(cmd_dir_in));

    // short ms so smoothing and ramp finish in a few hundred cycles
    position_command_gear_path #(.MS_CYCLES(100),
        .COUNTS_PER_REV(32'h0002_0000)) i_position_command_gear_path (
        .clk, .rst, .cmd_pulse_in, .cmd_dir_in, .pulse_count_block_in,
        .deviation_zero_in, .gear_switch_in, .gear_a_numerator,
        .gear_a_denominator, .gear_b_numerator, .gear_b_denominator,
        .gear_set_select, .command_smoothing_time, .ramp_accel_time,
        .ramp_decel_time, .command_input_options, .rated_rate,
        .motor_step_out, .motor_dir_out, .position_deviation,
        .active_gear_b, .scaler_busy);

    always @(posedge clk) begin
        if (motor_step_out === 1'b1) begin
            step_sum <= motor_dir_out === 1'b1 ? step_sum - 1 : step_sum + 1;
        end
    end

    task automatic check(input logic signed [39:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %0d, wanted %0d", $time, seen,
                     exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wait_idle();
        int quiet;
        quiet = 0;
        for (int n = 0; n < 5000 && quiet < 8; n++) begin
            @(negedge clk);
            quiet = scaler_busy === 1'b0 && position_deviation === '0 ?
                    quiet + 1 : 0;
        end
        check(quiet >= 8, 1'b1);
    endtask

    // other set gets 7/1 so a wrong selection shows in the count
    task automatic run_row(input row_s r);
        logic use_b;
        use_b = r.sel == 1 || (r.sel == 2 && r.pin == 1);
        @(posedge clk);
        gear_set_select        <= 2'(r.sel);
        gear_switch_in         <= r.pin[0];
        gear_a_numerator       <= use_b ? 16'h0007 : 16'(r.num);
        gear_a_denominator     <= use_b ? 16'h0001 : 16'(r.den);
        gear_b_numerator       <= use_b ? {16'h8000, 16'(r.num)} : 32'h0000_0007;
        gear_b_denominator     <= use_b ? 32'(r.den) : 32'h0000_0001;
        command_smoothing_time <= 14'(r.smooth);
        ramp_accel_time        <= r.ramp ? 14'h0002 : 14'h0000;
        ramp_decel_time        <= r.ramp ? 14'h0002 : 14'h0000;
        rated_rate             <= r.ramp ? 17'h0_0032 : 17'h0_0000;
        pulse_count_block_in   <= r.blk[0];
        command_input_options  <= 4'h2;
        deviation_zero_in      <= 1'b1;
        repeat (6) @(posedge clk);
        deviation_zero_in      <= 1'b0;
        command_input_options  <= {3'h0, r.inh[0]};
        base = step_sum;
        i_host_pulse_source.send(r.n, r.rev[0]);
        wait_idle();
        check(step_sum - base, r.exp);
        check(active_gear_b, use_b);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        check(position_deviation, '0);
        check(active_gear_b, 1'b0);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        @(posedge clk);
        gear_set_select        <= 2'h0;
        gear_a_numerator       <= 16'h0001;
        gear_a_denominator     <= 16'h0001;
        command_smoothing_time <= 14'h2710;
        command_input_options  <= 4'h0;
        pulse_count_block_in   <= 1'b0;
        i_host_pulse_source.send(20, 1'b0);
        deviation_zero_in      <= 1'b1;
        repeat (10) @(posedge clk);
        check(position_deviation != '0, 1'b1);
        command_input_options  <= 4'h2;
        repeat (3) @(posedge clk);
        base = step_sum;
        @(negedge clk);
        check(position_deviation, '0);
        @(posedge clk);
        deviation_zero_in      <= 1'b0;
        repeat (300) @(posedge clk);
        check(step_sum - base, '0);
        give_verdict();
    end
endmodule // test_position_command_gear_path
